/* rtl/bcm_pkg.sv */
/*
  Constants and carriers for the bus cycle code and monitor block.
  Assumes a single system clock; no other file depends on anything outside.
*/
package bcm_pkg;

  // Access-type codes.
  localparam logic [2:0] TC_USER_DATA = 3'h0;
  localparam logic [2:0] TC_RESERVED = 3'h1;
  localparam logic [2:0] TC_USER_INSN = 3'h2;
  localparam logic [2:0] TC_USER_FLOW = 3'h3;
  localparam logic [2:0] TC_SUPV_DATA = 3'h4;
  localparam logic [2:0] TC_SUPV_VECTOR = 3'h5;
  localparam logic [2:0] TC_SUPV_INSN = 3'h6;
  localparam logic [2:0] TC_SUPV_FLOW = 3'h7;

  // Core-state codes.
  localparam logic [3:0] CS_STALL = 4'h0;
  localparam logic [3:0] CS_EXCEPTION = 4'h2;
  localparam logic [3:0] CS_LOWPOWER = 4'h4;
  localparam logic [3:0] CS_DEBUG = 4'h6;
  localparam logic [3:0] CS_LAUNCH = 4'h8;
  localparam logic [3:0] CS_LAUNCH_MULTI = 4'h9;
  localparam logic [3:0] CS_LAUNCH_ACCEL = 4'ha;
  localparam logic [3:0] CS_LAUNCH_LITERAL = 4'hb;
  localparam logic [3:0] CS_LAUNCH_FLOW = 4'hc;
  localparam logic [3:0] CS_LAUNCH_RETURN = 4'hd;
  localparam logic [3:0] CS_LAUNCH_INDIRECT = 4'hf;

  // Monitor timeout periods in system clocks, by period-select value.
  localparam logic [6:0] MON_PERIOD_0 = 7'h08;
  localparam logic [6:0] MON_PERIOD_1 = 7'h10;
  localparam logic [6:0] MON_PERIOD_2 = 7'h20;
  localparam logic [6:0] MON_PERIOD_3 = 7'h40;

  // Reset value of the monitor counter.
  localparam logic [6:0] MON_COUNT_RESET = 7'h00;

  // Core activity as reported by the processor each cycle.
  typedef enum logic [3:0] {
    BCM_ACT_STALL,
    BCM_ACT_EXCEPTION,
    BCM_ACT_LOWPOWER,
    BCM_ACT_DEBUG,
    BCM_ACT_LAUNCH,
    BCM_ACT_LAUNCH_MULTI,
    BCM_ACT_LAUNCH_ACCEL,
    BCM_ACT_LAUNCH_LITERAL,
    BCM_ACT_LAUNCH_FLOW,
    BCM_ACT_LAUNCH_RETURN,
    BCM_ACT_LAUNCH_INDIRECT
  } bcm_act_t;

  // Description of a bus access at its start.
  typedef struct packed {
    logic supervisor;
    logic vector;
    logic instruction;
    logic literal;
    logic flow;
    logic external;
  } bcm_access_t;

  // Configuration bits.
  typedef struct packed {
    logic emulation;
    logic portEPinAssign;
    logic corePinEnable;
    logic [1:0] monitorPeriodSelect;
    logic monitorExternalSelect;
    logic monitorDebugDisable;
  } bcm_cfg_t;

endpackage

/* rtl/bcm_bus_monitor.sv */
/*
  Bus cycle annotation codes and bus-cycle timeout monitor.
  Assumes the bus unit pulses cycleStart once per bus cycle (each half of a
  split 32-bit access to a 16-bit port counts as its own cycle) and that all
  inputs are synchronous to clk.
*/
// Behaviour
// - Access-type pins driven in emulation mode, else only when port E assign set.
// - Access-type code encodes privilege and space: data, instruction, flow, vector.
// - Literal loads coded as instruction; flow code for taken branches and table fetches.
// - Core-state code on interrupt pins 5..2 in emulation or with pin enable.
// - Core-state codes for stall, exception, low power and debug.
// - Core-state launch codes for each instruction class.
// - Monitor counts clocks per bus cycle and on expiry ends the cycle with a bus error.
// - Timeout period 8, 16, 32 or 64 clocks from two-bit select.
// - Counter cleared at every bus access start; restarted only when the access is watched.
// - On expiry the monitor itself terminates the hung cycle.
// - Configuration bit picks internal-only or internal plus external monitoring.
// - Monitor may be disabled in debug mode for all accesses.
// - Each half of a split 32-bit external access is timed separately.
// - No interrupt request is produced; timeouts show only as bus error.
// - Cycle ends on acknowledge; error acknowledge beats a simultaneous normal one.
// - On timeout the internal transfer error acknowledge is asserted.
`timescale 1ns/1ps

module bcm_bus_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus cycle
  input wire logic cycleStart,
  input wire bcm_pkg::bcm_access_t access,
  input wire logic transferAck,
  input wire logic transferErrorAck,
  input wire logic internalAck,
  // Core activity
  input wire bcm_pkg::bcm_act_t coreActivity,
  // Configuration
  input wire bcm_pkg::bcm_cfg_t cfg,
  // Pins and results
  output logic [2:0] accessTypeCode,
  output logic [2:0] accessTypeCodeOe,
  output logic [3:0] coreStateCode,
  output logic [3:0] coreStatePinOe,
  output logic cycleDone,
  output logic cycleError,
  output logic internalErrorAck,
  output logic monitorBusy
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser.

  logic rstMeta_r;
  logic rstSync_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code functions.

  function automatic logic [2:0] accessCode(input bcm_pkg::bcm_access_t a);
    logic [2:0] c;
    c = bcm_pkg::TC_USER_DATA;
    // Literal loads count as instruction fetches, never data.
    if (a.vector && a.supervisor)
      c = bcm_pkg::TC_SUPV_VECTOR;
    else if (a.flow)
      c = a.supervisor ? bcm_pkg::TC_SUPV_FLOW : bcm_pkg::TC_USER_FLOW;
    else if (a.instruction || a.literal)
      c = a.supervisor ? bcm_pkg::TC_SUPV_INSN : bcm_pkg::TC_USER_INSN;
    else
      c = a.supervisor ? bcm_pkg::TC_SUPV_DATA : bcm_pkg::TC_USER_DATA;
    return c;
  endfunction

  function automatic logic [3:0] stateCode(input bcm_pkg::bcm_act_t a);
    logic [3:0] c;
    c = bcm_pkg::CS_STALL;
    case (a)
      bcm_pkg::BCM_ACT_STALL: c = bcm_pkg::CS_STALL;
      bcm_pkg::BCM_ACT_EXCEPTION: c = bcm_pkg::CS_EXCEPTION;
      bcm_pkg::BCM_ACT_LOWPOWER: c = bcm_pkg::CS_LOWPOWER;
      bcm_pkg::BCM_ACT_DEBUG: c = bcm_pkg::CS_DEBUG;
      bcm_pkg::BCM_ACT_LAUNCH: c = bcm_pkg::CS_LAUNCH;
      bcm_pkg::BCM_ACT_LAUNCH_MULTI: c = bcm_pkg::CS_LAUNCH_MULTI;
      bcm_pkg::BCM_ACT_LAUNCH_ACCEL: c = bcm_pkg::CS_LAUNCH_ACCEL;
      bcm_pkg::BCM_ACT_LAUNCH_LITERAL: c = bcm_pkg::CS_LAUNCH_LITERAL;
      bcm_pkg::BCM_ACT_LAUNCH_FLOW: c = bcm_pkg::CS_LAUNCH_FLOW;
      bcm_pkg::BCM_ACT_LAUNCH_RETURN: c = bcm_pkg::CS_LAUNCH_RETURN;
      bcm_pkg::BCM_ACT_LAUNCH_INDIRECT: c = bcm_pkg::CS_LAUNCH_INDIRECT;
      default: c = bcm_pkg::CS_STALL;
    endcase
    return c;
  endfunction

  function automatic logic [6:0] periodLimit(input logic [1:0] sel);
    logic [6:0] p;
    p = bcm_pkg::MON_PERIOD_0;
    case (sel)
      2'h0: p = bcm_pkg::MON_PERIOD_0;
      2'h1: p = bcm_pkg::MON_PERIOD_1;
      2'h2: p = bcm_pkg::MON_PERIOD_2;
      2'h3: p = bcm_pkg::MON_PERIOD_3;
      default: p = bcm_pkg::MON_PERIOD_0;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access-type code, held for the whole cycle.

  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
      accessTypeCode <= bcm_pkg::TC_USER_DATA;
    else if (cycleStart)
      accessTypeCode <= accessCode(access);
  end

  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
      accessTypeCodeOe <= 3'h0;
    else
      accessTypeCodeOe <= {3{cfg.emulation | cfg.portEPinAssign}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-state code on the interrupt pins.

  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
      coreStateCode <= bcm_pkg::CS_STALL;
    else
      coreStateCode <= stateCode(coreActivity);
  end

  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
      coreStatePinOe <= 4'h0;
    else
      coreStatePinOe <= {4{cfg.emulation | cfg.corePinEnable}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus monitor.
  // The counter stops while no cycle is open, so an idle bus never times out.

  typedef enum logic [1:0] {MON_IDLE, MON_TIMING, MON_OPEN} bcm_mon_t;

  bcm_mon_t monState_r;
  logic [6:0] monCount_r;
  logic monArm;
  logic timeout;
  logic anyAck;

  // Whether this access is watched: external ones only on request, none in debug when monitorDebugDisable is set.
  assign monArm = (!access.external || cfg.monitorExternalSelect)
    && !(cfg.monitorDebugDisable && coreActivity == bcm_pkg::BCM_ACT_DEBUG);
  assign anyAck = transferAck || internalAck || transferErrorAck;
  assign timeout = monState_r == MON_TIMING && !anyAck
    && monCount_r == periodLimit(cfg.monitorPeriodSelect) - 7'h01;

  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      monState_r <= MON_IDLE;
      monCount_r <= bcm_pkg::MON_COUNT_RESET;
    end
    else if (cycleStart)
    begin
      // Each half of a split access arrives with its own start.
      monState_r <= monArm ? MON_TIMING : MON_OPEN;
      monCount_r <= bcm_pkg::MON_COUNT_RESET;
    end
    else
    begin
      case (monState_r)
        MON_IDLE: monState_r <= MON_IDLE;
        MON_TIMING:
        begin
          if (anyAck || timeout)
            monState_r <= MON_IDLE;
          else
            monCount_r <= monCount_r + 7'h01;
        end
        MON_OPEN:
        begin
          if (anyAck)
            monState_r <= MON_IDLE;
        end
        default: monState_r <= MON_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination. No interrupt output exists; errors end the cycle only.

  always_comb
  begin
    internalErrorAck = timeout;
    cycleDone = (monState_r != MON_IDLE) && (anyAck || timeout);
    cycleError = cycleDone && (transferErrorAck || timeout);
    monitorBusy = monState_r == MON_TIMING;
  end

endmodule

/* sim/bcm_slave_model.sv */
/*
  Behavioural far-side slave that answers bus cycles with acknowledges.
  Assumes the bench sets the wait and error mode before each cycle start.
*/
`timescale 1ns/1ps
module bcm_slave_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Cycle and answer
  input wire logic cycleStart,
  input wire logic [6:0] waitCycles,
  input wire logic errMode,
  output logic transferAck,
  output logic transferErrorAck
);
  logic [6:0] cntR;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cntR <= 7'h00;
    else
      cntR <= cycleStart ? 7'h01 : cntR + 7'h01;
  end
  // A zero wait never answers, which is how a dead peripheral is modelled.
  assign transferAck = cntR == waitCycles && waitCycles != 7'h00;
  assign transferErrorAck = transferAck && errMode;
endmodule

/* sim/bcm_bus_monitor_assertions.sv */
/*
  Concurrent checks on the bus cycle code and monitor block.
  Assumes it is bound onto bcm_bus_monitor and sees only its ports.
*/
`timescale 1ns/1ps
module bcm_bus_monitor_assertions
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Inputs
  input wire logic cycleStart,
  input wire bcm_pkg::bcm_access_t access,
  input wire logic transferAck,
  input wire logic transferErrorAck,
  input wire logic internalAck,
  input wire bcm_pkg::bcm_act_t coreActivity,
  input wire bcm_pkg::bcm_cfg_t cfg,
  // Outputs
  input wire logic [2:0] accessTypeCode,
  input wire logic [2:0] accessTypeCodeOe,
  input wire logic [3:0] coreStateCode,
  input wire logic [3:0] coreStatePinOe,
  input wire logic cycleDone,
  input wire logic cycleError,
  input wire logic internalErrorAck
);
  localparam logic [43:0] STATE_TAB = 44'hfdcba986420;
  logic [6:0] elapsedR;
  logic openR;
  logic watchR;
  logic [2:0] liveR;
  wire logic [6:0] period = 7'h08 << cfg.monitorPeriodSelect;
  wire logic watchNow = !(access.external && !cfg.monitorExternalSelect)
    && !(cfg.monitorDebugDisable && coreActivity == bcm_pkg::BCM_ACT_DEBUG);
  wire logic [2:0] tcExp = (access.supervisor && access.vector) ? 3'h5
    : {access.supervisor, access.instruction | access.literal | access.flow, access.flow};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Elapsed count saturates so a long unwatched cycle never wraps back round.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      elapsedR <= 7'h00;
      openR <= 1'b0;
      watchR <= 1'b0;
      liveR <= 3'h0;
    end
    else
    begin
      liveR <= {liveR[1:0], 1'b1};
      elapsedR <= cycleStart ? 7'h01 : elapsedR + {6'h00, elapsedR != 7'h00 && elapsedR != 7'h7f};
      openR <= cycleStart || (openR && !(transferAck || transferErrorAck || internalAck || internalErrorAck));
      watchR <= cycleStart ? watchNow : watchR;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_timeout_at_period: assert property (internalErrorAck |-> elapsedR == period)
    else $error("timeout at wrong count");
  a_timeout_due: assert property (openR && watchR && elapsedR == period |-> cycleDone && cycleError)
    else $error("hung cycle not ended");
  a_unwatched_quiet: assert property (!watchR |-> !internalErrorAck)
    else $error("unwatched cycle timed out");
  a_error_ack_wins: assert property (openR && transferErrorAck |-> cycleDone && cycleError)
    else $error("error ack not honoured");
  a_normal_ack_end: assert property (openR && (transferAck || internalAck) && !transferErrorAck
    && !internalErrorAck |-> cycleDone && !cycleError)
    else $error("normal ack not honoured");
  a_stray_ack_ignored: assert property (!openR |-> !cycleDone)
    else $error("done without open cycle");
  a_code_holds: assert property (!cycleStart |=> $stable(accessTypeCode))
    else $error("access code moved mid cycle");
  a_code_loaded: assert property (cycleStart |=> accessTypeCode == $past(tcExp))
    else $error("access code wrong");
  a_state_code: assert property (liveR[2] |-> coreStateCode == STATE_TAB[$past(coreActivity) * 4 +: 4])
    else $error("core state code wrong");
  a_pin_enables: assert property (liveR[2] |-> accessTypeCodeOe == {3{$past(cfg.emulation || cfg.portEPinAssign)}}
    && coreStatePinOe == {4{$past(cfg.emulation || cfg.corePinEnable)}})
    else $error("pin enables wrong");
endmodule
bind bcm_bus_monitor bcm_bus_monitor_assertions bcm_bus_monitor_assertions_inst (.clk(clk), .rst_b(rst_b),
  .cycleStart(cycleStart), .access(access), .transferAck(transferAck), .transferErrorAck(transferErrorAck),
  .internalAck(internalAck), .coreActivity(coreActivity), .cfg(cfg), .accessTypeCode(accessTypeCode),
  .accessTypeCodeOe(accessTypeCodeOe), .coreStateCode(coreStateCode), .coreStatePinOe(coreStatePinOe),
  .cycleDone(cycleDone), .cycleError(cycleError), .internalErrorAck(internalErrorAck));

/* sim/bcm_bus_monitor_tb_top.sv */
/*
  Self-checking bench for the bus cycle code and monitor block.
  Assumes the slave model answers each cycle given a nonzero wait and inputs move on falling edges.
*/
`timescale 1ns/1ps
module bcm_bus_monitor_tb_top;
  localparam logic [43:0] STATE_TAB = 44'hfdcba986420;
  logic clk, rst_b, cycleStart, transferAck, transferErrorAck, internalAck, errMode, e;
  logic cycleDone, cycleError, internalErrorAck, monitorBusy;
  logic [2:0] accessTypeCode, accessTypeCodeOe;
  logic [3:0] coreStateCode, coreStatePinOe;
  logic [6:0] waitCycles;
  logic [31:0] lfsr = 32'hf81712e2;
  bcm_pkg::bcm_access_t access, a;
  bcm_pkg::bcm_act_t coreActivity;
  bcm_pkg::bcm_cfg_t cfg;
  int fails = 0, totalChecks = 0, cyc = 0, n, w;
  bcm_bus_monitor bcm_bus_monitor_inst (.clk(clk), .rst_b(rst_b), .cycleStart(cycleStart), .access(access),
    .transferAck(transferAck), .transferErrorAck(transferErrorAck), .internalAck(internalAck),
    .coreActivity(coreActivity), .cfg(cfg), .accessTypeCode(accessTypeCode), .accessTypeCodeOe(accessTypeCodeOe),
    .coreStateCode(coreStateCode), .coreStatePinOe(coreStatePinOe), .cycleDone(cycleDone),
    .cycleError(cycleError), .internalErrorAck(internalErrorAck), .monitorBusy(monitorBusy));
  bcm_slave_model bcm_slave_model_inst (.clk(clk), .rst_b(rst_b), .cycleStart(cycleStart),
    .waitCycles(waitCycles), .errMode(errMode), .transferAck(transferAck), .transferErrorAck(transferErrorAck));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [2:0] tcf(bcm_pkg::bcm_access_t x);
    if (x.supervisor && x.vector)
      return 3'h5;
    return {x.supervisor, x.instruction | x.literal | x.flow, x.flow};
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A done index of 71 means the cycle was never ended within the window.
  task automatic run(bcm_pkg::bcm_access_t x, int wt, logic em, int expK, logic expErr);
    int k;
    access = x;
    waitCycles = 7'(wt);
    errMode = em;
    cycleStart = 1'b1;
    @(negedge clk);
    cycleStart = 1'b0;
    chk(8'(accessTypeCode), 8'(tcf(x)));
    chk(8'(monitorBusy), 8'(expK != 71));
    k = 1;
    while (k <= 70 && cycleDone !== 1'b1)
    begin
      k++;
      @(negedge clk);
    end
    chk(8'(cycleError), 8'(expErr));
    chk(8'(k), 8'(expK));
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      wrap_up();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    cycleStart = 1'b0;
    internalAck = 1'b0;
    waitCycles = 7'h00;
    errMode = 1'b0;
    access = '0;
    coreActivity = bcm_pkg::BCM_ACT_LAUNCH;
    cfg = '0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 11; i++)
    begin
      cfg = 7'(rnd());
      coreActivity = bcm_pkg::bcm_act_t'(i);
      @(negedge clk);
      chk(8'(coreStateCode), 8'(STATE_TAB[i * 4 +: 4]));
      chk(8'(accessTypeCodeOe), 8'({3{cfg.emulation | cfg.portEPinAssign}}));
      chk(8'(coreStatePinOe), 8'({4{cfg.emulation | cfg.corePinEnable}}));
    end
    coreActivity = bcm_pkg::BCM_ACT_LAUNCH;
    for (int s = 0; s < 4; s++)
    begin
      cfg = '0;
      cfg.monitorPeriodSelect = 2'(s);
      cfg.monitorExternalSelect = 1'b1;
      n = 8 << s;
      a = 6'(rnd());
      w = 1 + int'(rnd() % 32'(n - 1));
      e = lfsr[3];
      run(a, w, e, w, e);
      run(6'(rnd()), 0, 1'b0, n, 1'b1);
    end
    cfg.monitorPeriodSelect = 2'h0;
    cycleStart = 1'b1;
    @(negedge clk);
    cycleStart = 1'b0;
    repeat (4) @(negedge clk);
    run(6'h01, 0, 1'b0, 8, 1'b1);
    run(6'h01, 0, 1'b0, 8, 1'b1);
    cfg.monitorExternalSelect = 1'b0;
    run(6'h01, 0, 1'b0, 71, 1'b0);
    cfg.monitorDebugDisable = 1'b1;
    coreActivity = bcm_pkg::BCM_ACT_DEBUG;
    run(6'h00, 0, 1'b0, 71, 1'b0);
    coreActivity = bcm_pkg::BCM_ACT_LAUNCH;
    run(6'h20, 0, 1'b0, 8, 1'b1);
    internalAck = 1'b1;
    #5;
    chk(8'(cycleDone), 8'h00);
    @(negedge clk);
    internalAck = 1'b0;
    @(negedge clk);
    wrap_up();
  end
endmodule
